// file: hdl/sarc_pkg.sv
// Package of the sleep and reset control block: offsets, fields, resets, timing.
// Assumes a byte-wide register port with one-cycle read latency.
package sarc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0] SARC_SMC_OFS     = 8'h33;
  localparam logic [7:0] SARC_CBS_OFS     = 8'h35;
  localparam logic [7:0] SARC_PCG_OFS     = 8'h64;
  localparam logic [7:0] SARC_RSTSTAT_OFS = 8'h34;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int SARC_SE_BIT      = 0;
  localparam int SARC_SM_LSB      = 1;
  localparam int SARC_BROWNOUT_OFF_IN_SLEEP_BIT    = 6;
  localparam int SARC_BROWNOUT_SLEEP_WRITE_ENABLE_BIT   = 5;
  localparam int SARC_G_LCD_BIT   = 4;
  localparam int SARC_G_TIM_BIT   = 3;
  localparam int SARC_G_SPI_BIT   = 2;
  localparam int SARC_G_USART_BIT = 1;
  localparam int SARC_G_ADC_BIT   = 0;

  // ----------------------------------------------------------------------
  // Reset values and masks.
  // ----------------------------------------------------------------------
  localparam logic [7:0] SARC_SMC_RST   = 8'h00;
  localparam logic [7:0] SARC_CBS_RST   = 8'h00;
  localparam logic [7:0] SARC_PCG_RST   = 8'h00;
  localparam logic [7:0] SARC_PCG_MASK  = 8'h1F;

  // ----------------------------------------------------------------------
  // Timing counts in core clock cycles.
  // ----------------------------------------------------------------------
  localparam int SARC_BROWNOUT_SLEEP_WRITE_ENABLE_WIN_CYC  = 4;
  localparam int SARC_BROWNOUT_OFF_IN_SLEEP_DELAY_CYC = 3;
  localparam int SARC_BROWNOUT_OFF_IN_SLEEP_HOLD_CYC  = 3;
  localparam int SARC_STANDBY_WAKE_CYC = 6;
  localparam int SARC_TOUT_DEFAULT   = 8192;

  // Sleep mode codes.
  typedef enum logic [2:0] {
    SARC_MODE_IDLE    = 3'b000,
    SARC_MODE_ADCNR   = 3'b001,
    SARC_MODE_PDOWN   = 3'b010,
    SARC_MODE_PSAVE   = 3'b011,
    SARC_MODE_RES4    = 3'b100,
    SARC_MODE_RES5    = 3'b101,
    SARC_MODE_STANDBY = 3'b110,
    SARC_MODE_RES7    = 3'b111
  } sarc_mode_type;

  // Sleep controller states.
  typedef enum logic [1:0] {
    SARC_AWAKE = 2'b00,
    SARC_ASLEEP = 2'b01,
    SARC_WAKING = 2'b10
  } sarc_state_type;

endpackage

// file: hdl/sarc_top.sv
// Sleep, brown-out-in-sleep, clock gating and reset combining for a small MCU.
// Assumes reset sources arrive as levels from analog cells or other logic,
// and that the core reports a sleep instruction as a one-cycle pulse.
//
// Contract
// - sleep mode field codes: idle, ADC noise, power-down, power-save, standby; others reserved.
// - sleep instruction enters sleep only while sleep entry enable is one.
// - brownout-off bit sets only by write-enable write, then bit write within four cycles.
// - brownout-off bit active three cycles after set, cleared three cycles later.
// - detector off in sleep only if sleep executes while brownout-off bit is active.
// - gating bit 4 shuts LCD; software disables LCD first.
// - gating bit 3 shuts 16-bit timer; clearing resumes it unchanged.
// - gating bit 2 stops SPI clock; software reinitialises SPI.
// - gating bit 1 stops USART clock; software reinitialises USART.
// - gating bit 0 shuts ADC; comparator loses ADC multiplexer meanwhile.
// - upper three gating bits read as zero.
// - any reset loads initial register values; execution restarts at reset vector.
// - I/O ports return to initial state at once, without clock.
// - internal reset stretched by fuse-selected delay counter after sources release.
// - internal reset combines power-on, pin, watchdog, brown-out and debug reset.
// - long low pin pulse resets without clock; delay starts on release.
// - power-on low supply reasserts reset at once; only release is delayed.
// - enabled brown-out asserts reset immediately; release after time-out.
// - watchdog reset is one clock pulse; delay starts on its falling edge.
// - reset held while debug reset register holds one.
// - watchdog expiry resets only when watchdog enabled.
// - gated module frozen, registers inaccessible, resumes unchanged on clear.
// - standby wake resumes after six clock cycles.
`timescale 1ns/1ps
`default_nettype none

module sarc_top
  import sarc_pkg::*;
#(
  parameter int TOUT_CYC = sarc_pkg::SARC_TOUT_DEFAULT  // Reset stretch length.
) (
  input  wire logic       core_clk,          // System clock, 125 MHz.
  input  wire logic       rst,               // Asynchronous reset, active high.
  input  wire logic [7:0] reg_addr,          // Register address.
  input  wire logic [7:0] reg_wdata,         // Register write data.
  input  wire logic       reg_wr,            // Write strobe.
  input  wire logic       reg_rd,            // Read strobe.
  output logic      [7:0] reg_rdata,         // Read data, one cycle after strobe.
  input  wire logic       sleep_instr,       // Core executes sleep, one pulse.
  input  wire logic       wake_event,        // Wake-up request, level.
  input  wire logic       standby_osc_ok,    // External crystal clock selected.
  output logic            sleep_active,      // Core halted in sleep.
  output logic      [2:0] sleep_mode_out,    // Mode in force while asleep.
  output logic            core_resume,       // One pulse when execution resumes.
  output logic            brownout_detector_off, // Detector powered down for sleep.
  output logic            gate_lcd_controller, // LCD shut down.
  output logic            gate_timer_16bit,  // 16-bit timer clock stopped.
  output logic            gate_spi_module,   // SPI clock stopped.
  output logic            gate_usart_module, // USART clock stopped.
  output logic            gate_adc_module,   // ADC shut down.
  output logic            comparator_mux_block, // Comparator denied ADC multiplexer.
  input  wire logic       por_low,           // Power-on detector: supply low.
  input  wire logic       ext_reset_n,       // External reset pin, active low.
  input  wire logic       wdt_expire,        // Watchdog period expired pulse.
  input  wire logic       wdt_enabled,       // Watchdog enabled level.
  input  wire logic       brownout_low,      // Brown-out comparator: supply low.
  input  wire logic       brownout_en,       // Brown-out detector enabled by fuse.
  input  wire logic       debug_reset_reg,   // Debug scan reset register content.
  output logic            source_reset,      // Unclocked OR of sources, for ports.
  output logic            internal_reset     // Stretched internal reset.
);

  // ----------------------------------------------------------------------
  // Reset combining.
  // ----------------------------------------------------------------------

  // Watchdog pulse is a registered one-clock pulse, only when enabled.
  logic wdt_pulse_r;
  wire  wdt_pulse_nxt = wdt_expire & wdt_enabled;

  // Asynchronous sources act without a clock; the watchdog pulse rides along.
  wire  bod_src = brownout_low & brownout_en;
  wire  async_src = por_low | ~ext_reset_n | bod_src
                    | debug_reset_reg | rst;
  assign source_reset = async_src | wdt_pulse_r;

  always_ff @(posedge core_clk or posedge async_src) begin
    if (async_src) begin
      wdt_pulse_r <= 1'b0;
    end else begin
      wdt_pulse_r <= wdt_pulse_nxt & ~wdt_pulse_r;
    end
  end

  // Release of the sources is synchronised before the stretch counter starts.
  // Three stages; the counter starts once the second and third agree released.
  logic [2:0] rel_sync_r;
  always_ff @(posedge core_clk or posedge source_reset) begin
    if (source_reset) begin
      rel_sync_r <= 3'b000;
    end else begin
      rel_sync_r <= {rel_sync_r[1:0], 1'b1};
    end
  end
  wire released = rel_sync_r[2] & rel_sync_r[1];

  // Stretch counter: assertion is immediate, release waits TOUT_CYC cycles.
  // Watchdog pulse clears the counter, so counting begins only once its falling edge has passed the synchroniser.
  localparam int TW = $clog2(TOUT_CYC + 1);
  logic [TW-1:0] tout_cnt_r;
  logic          int_rst_r;
  wire  tout_done = (tout_cnt_r == TW'(TOUT_CYC - 1));
  always_ff @(posedge core_clk or posedge source_reset) begin
    if (source_reset) begin
      tout_cnt_r <= '0;
      int_rst_r  <= 1'b1;
    end else if (released & int_rst_r) begin
      tout_cnt_r <= tout_cnt_r + TW'(1);
      int_rst_r  <= ~tout_done;
    end
  end
  assign internal_reset = int_rst_r | source_reset;

  // Every register below is reset by the internal reset.
  wire rrst = internal_reset;

  // ----------------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------------
  wire wr_smc = reg_wr & (reg_addr == SARC_SMC_OFS);
  wire wr_cbs = reg_wr & (reg_addr == SARC_CBS_OFS);
  wire wr_pcg = reg_wr & (reg_addr == SARC_PCG_OFS);

  logic [7:0] smc_r;
  logic [7:0] pcg_r;
  always_ff @(posedge core_clk or posedge rrst) begin
    if (rrst) begin
      smc_r <= SARC_SMC_RST;
      pcg_r <= SARC_PCG_RST;
    end else begin
      if (wr_smc) smc_r <= reg_wdata & 8'h0F;
      if (wr_pcg) pcg_r <= reg_wdata & SARC_PCG_MASK;
    end
  end

  wire sleep_entry_enable = smc_r[SARC_SE_BIT];
  wire [2:0] sleep_mode_select = smc_r[SARC_SM_LSB +: 3];

  // ----------------------------------------------------------------------
  // Brown-out-off-in-sleep timed sequence.
  // ----------------------------------------------------------------------
  // Write enable opens a four-cycle window; a bit write inside arms the bit,
  // which becomes active three cycles later and clears three cycles after.
  logic       brownout_sleep_write_enable_r;
  logic [2:0] win_cnt_r;
  logic       brownout_off_in_sleep_r;
  logic [2:0] brownout_off_in_sleep_cnt_r;
  logic       brownout_off_in_sleep_act_r;
  wire w_brownout_off_in_sleep  = reg_wdata[SARC_BROWNOUT_OFF_IN_SLEEP_BIT];
  wire w_brownout_sleep_write_enable = reg_wdata[SARC_BROWNOUT_SLEEP_WRITE_ENABLE_BIT];
  wire open_win = wr_cbs & w_brownout_off_in_sleep & w_brownout_sleep_write_enable;
  wire set_brownout_off_in_sleep = wr_cbs & w_brownout_off_in_sleep & ~w_brownout_sleep_write_enable & brownout_sleep_write_enable_r;

  always_ff @(posedge core_clk or posedge rrst) begin
    if (rrst) begin
      brownout_sleep_write_enable_r   <= 1'b0;
      win_cnt_r <= 3'h0;
    end else if (open_win) begin
      brownout_sleep_write_enable_r   <= 1'b1;
      win_cnt_r <= 3'(SARC_BROWNOUT_SLEEP_WRITE_ENABLE_WIN_CYC - 1);
    end else if (brownout_sleep_write_enable_r) begin
      brownout_sleep_write_enable_r   <= (win_cnt_r != 3'h0);
      win_cnt_r <= win_cnt_r - 3'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rrst) begin
    if (rrst) begin
      brownout_off_in_sleep_r     <= 1'b0;
      brownout_off_in_sleep_act_r <= 1'b0;
      brownout_off_in_sleep_cnt_r <= 3'h0;
    end else if (set_brownout_off_in_sleep) begin
      brownout_off_in_sleep_r     <= 1'b1;
      brownout_off_in_sleep_act_r <= 1'b0;
      brownout_off_in_sleep_cnt_r <= 3'(SARC_BROWNOUT_OFF_IN_SLEEP_DELAY_CYC - 1);
    end else if (brownout_off_in_sleep_r & ~brownout_off_in_sleep_act_r) begin
      if (brownout_off_in_sleep_cnt_r == 3'h0) begin
        brownout_off_in_sleep_act_r <= 1'b1;
        brownout_off_in_sleep_cnt_r <= 3'(SARC_BROWNOUT_OFF_IN_SLEEP_HOLD_CYC - 1);
      end else begin
        brownout_off_in_sleep_cnt_r <= brownout_off_in_sleep_cnt_r - 3'h1;
      end
    end else if (brownout_off_in_sleep_act_r) begin
      if (brownout_off_in_sleep_cnt_r == 3'h0) begin
        brownout_off_in_sleep_r     <= 1'b0;
        brownout_off_in_sleep_act_r <= 1'b0;
      end else begin
        brownout_off_in_sleep_cnt_r <= brownout_off_in_sleep_cnt_r - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sleep controller.
  // ----------------------------------------------------------------------
  wire mode_ok = (sleep_mode_select == SARC_MODE_IDLE)
               | (sleep_mode_select == SARC_MODE_ADCNR)
               | (sleep_mode_select == SARC_MODE_PDOWN)
               | (sleep_mode_select == SARC_MODE_PSAVE)
               | (sleep_mode_select == SARC_MODE_STANDBY);
  wire go_sleep = sleep_instr & sleep_entry_enable & mode_ok;
  // Standby needs an external crystal; otherwise it falls back to power-down.
  wire [2:0] eff_mode = ((sleep_mode_select == SARC_MODE_STANDBY) & ~standby_osc_ok)
                        ? SARC_MODE_PDOWN : sleep_mode_select;

  sarc_state_type st_r;
  logic [2:0]     mode_r;
  logic           bod_off_r;
  logic [2:0]     wake_cnt_r;
  logic           resume_r;
  always_ff @(posedge core_clk or posedge rrst) begin
    if (rrst) begin
      st_r       <= SARC_AWAKE;
      mode_r     <= 3'h0;
      bod_off_r  <= 1'b0;
      wake_cnt_r <= 3'h0;
      resume_r   <= 1'b0;
    end else begin
      resume_r <= 1'b0;
      unique case (st_r)
        SARC_AWAKE: begin
          if (go_sleep) begin
            st_r      <= SARC_ASLEEP;
            mode_r    <= eff_mode;
            bod_off_r <= brownout_off_in_sleep_act_r;
          end
        end
        SARC_ASLEEP: begin
          if (wake_event) begin
            bod_off_r <= 1'b0;
            if (mode_r == SARC_MODE_STANDBY) begin
              st_r       <= SARC_WAKING;
              wake_cnt_r <= 3'(SARC_STANDBY_WAKE_CYC - 1);
            end else begin
              st_r     <= SARC_AWAKE;
              resume_r <= 1'b1;
            end
          end
        end
        SARC_WAKING: begin
          if (wake_cnt_r == 3'h0) begin
            st_r     <= SARC_AWAKE;
            resume_r <= 1'b1;
          end else begin
            wake_cnt_r <= wake_cnt_r - 3'h1;
          end
        end
        default: st_r <= SARC_AWAKE;
      endcase
    end
  end

  assign sleep_active          = (st_r != SARC_AWAKE);
  assign sleep_mode_out        = mode_r;
  assign core_resume           = resume_r;
  assign brownout_detector_off = bod_off_r;

  // ----------------------------------------------------------------------
  // Peripheral gating; modules hold state while their clock is stopped.
  // ----------------------------------------------------------------------
  assign gate_lcd_controller  = pcg_r[SARC_G_LCD_BIT];
  assign gate_timer_16bit     = pcg_r[SARC_G_TIM_BIT];
  assign gate_spi_module      = pcg_r[SARC_G_SPI_BIT];
  assign gate_usart_module    = pcg_r[SARC_G_USART_BIT];
  assign gate_adc_module      = pcg_r[SARC_G_ADC_BIT];
  assign comparator_mux_block = pcg_r[SARC_G_ADC_BIT];

  // ----------------------------------------------------------------------
  // Status and read path.
  // ----------------------------------------------------------------------
  // Status: bit0 asleep, bit1 brownout-off armed, bit2 active, bit3 window open.
  wire [7:0] stat_nxt = {4'h0, brownout_sleep_write_enable_r, brownout_off_in_sleep_act_r, brownout_off_in_sleep_r, sleep_active};
  // Each bit is widened before the shift, so no bit falls off the top.
  wire [7:0] cbs_view = (8'(brownout_off_in_sleep_r) << SARC_BROWNOUT_OFF_IN_SLEEP_BIT) | (8'(brownout_sleep_write_enable_r) << SARC_BROWNOUT_SLEEP_WRITE_ENABLE_BIT);
  wire [7:0] rd_mux = (reg_addr == SARC_SMC_OFS)     ? smc_r :
                      (reg_addr == SARC_CBS_OFS)     ? cbs_view :
                      (reg_addr == SARC_PCG_OFS)     ? pcg_r :
                      (reg_addr == SARC_RSTSTAT_OFS) ? stat_nxt : 8'h00;

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or posedge rrst) begin
    if (rrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

// file: tb/sarc_core_model.sv
// Model of the core: issues sleep instructions and wakes after a delay.
// Assumes the bench asks for a sleep with a one-cycle request.
`timescale 1ns/1ps
`default_nettype none

module sarc_core_model #(
  parameter int WAKE_DLY = 3  // Cycles asleep before waking.
) (
  input  wire logic core_clk,     // Clock.
  input  wire logic rst,          // Reset.
  input  wire logic go,           // Bench asks for a sleep.
  input  wire logic sleep_active, // Core halted.
  output logic      sleep_instr,  // Sleep instruction pulse.
  output logic      wake_event    // Wake request level.
);
  int unsigned cnt_r;  // Cycles spent asleep.

  // The wake request holds until the block leaves sleep, as a pin would.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_instr <= 1'b0;
      wake_event <= 1'b0;
      cnt_r <= 0;
    end else begin
      sleep_instr <= go;
      if (!sleep_active) begin
        cnt_r <= 0;
        wake_event <= 1'b0;
      end else if (cnt_r == WAKE_DLY) wake_event <= 1'b1;
      else cnt_r <= cnt_r + 1;
    end
  end
endmodule

`default_nettype wire

// file: tb/sarc_top_chk.sv
// Checker for the sleep and reset control block.
// Assumes it is bound to sarc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module sarc_top_chk #(
  parameter int TOUT_CYC = sarc_pkg::SARC_TOUT_DEFAULT  // Reset stretch length.
) (
  input wire logic       core_clk,              // Clock.
  input wire logic       rst,                   // Reset.
  input wire logic [7:0] reg_addr,              // Address.
  input wire logic       reg_rd,                // Read strobe.
  input wire logic [7:0] reg_rdata,             // Read data.
  input wire logic       sleep_instr,           // Sleep pulse.
  input wire logic       sleep_active,          // Asleep.
  input wire logic       core_resume,           // Resume pulse.
  input wire logic       brownout_detector_off, // Detector off.
  input wire logic       gate_adc_module,       // ADC gated.
  input wire logic       comparator_mux_block,  // Mux denied.
  input wire logic       por_low,               // Supply low.
  input wire logic       ext_reset_n,           // Pin.
  input wire logic       debug_reset_reg,       // Debug reset.
  input wire logic       brownout_low,          // Brown-out.
  input wire logic       brownout_en,           // Detector on.
  input wire logic       wdt_expire,            // Watchdog expiry.
  input wire logic       wdt_enabled,           // Watchdog on.
  input wire logic       source_reset,          // Raw reset.
  input wire logic       internal_reset         // Stretched reset.
);
  import sarc_pkg::*;

  int unsigned rel_cnt_r;  // Cycles since every source went quiet.

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Counts the stretch so its length can be judged at the release.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) rel_cnt_r <= 0;
    else if (source_reset) rel_cnt_r <= 0;
    else if (internal_reset) rel_cnt_r <= rel_cnt_r + 1;
  end

  // ----
  // Assertions.
  // ----
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  AST_PCG_RSVD: assert property (reg_rd && reg_addr == SARC_PCG_OFS |=> reg_rdata[7:5] == 3'h0)
    else $error("reserved gating bits read nonzero");
  AST_ADC_CMP: assert property (comparator_mux_block == gate_adc_module)
    else $error("comparator block differs from ADC gate");
  AST_SRC: assert property (por_low || !ext_reset_n || debug_reset_reg || (brownout_low && brownout_en)
    |-> source_reset && internal_reset)
    else $error("reset source did not reset");
  AST_STRETCH: assert property ($fell(internal_reset) |-> rel_cnt_r >= TOUT_CYC)
    else $error("internal reset released early");
  AST_WDT: assert property ($rose(wdt_expire) && wdt_enabled && !source_reset
    |=> source_reset ##1 !source_reset)
    else $error("watchdog pulse not one cycle");
  AST_SLEEP_CAUSE: assert property ($rose(sleep_active) |-> $past(sleep_instr))
    else $error("sleep without instruction");
  AST_BOD_OFF: assert property ($rose(brownout_detector_off) |-> $rose(sleep_active))
    else $error("detector off outside sleep entry");
  AST_RESUME: assert property (core_resume |-> !sleep_active && $past(sleep_active))
    else $error("resume pulse out of place");

  // A few of the main scenarios.
  cover property ($rose(sleep_active));
  cover property ($rose(brownout_detector_off));
  cover property ($fell(internal_reset));
endmodule

bind sarc_top sarc_top_chk #(.TOUT_CYC(TOUT_CYC)) sarc_top_chk_inst (.core_clk, .rst, .reg_addr, .reg_rd,
  .reg_rdata, .sleep_instr, .sleep_active, .core_resume, .brownout_detector_off, .gate_adc_module,
  .comparator_mux_block, .por_low, .ext_reset_n, .debug_reset_reg, .brownout_low, .brownout_en,
  .wdt_expire, .wdt_enabled, .source_reset, .internal_reset);

`default_nettype wire

// file: tb/sarc_top_tb.sv
// Testbench of the sleep and reset control block.
// Assumes the core model and checker files are compiled beside it.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module sarc_top_tb;
  import sarc_pkg::*;
  localparam int TOUT = 8;
  localparam logic [2:0] MODES [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};
  localparam logic [7:0] REFUSE [4] = '{8'h09, 8'h0B, 8'h0F, 8'h04};
  localparam logic [7:0] ADDRS [4] = '{SARC_SMC_OFS, SARC_CBS_OFS, SARC_PCG_OFS, 8'h10};
  logic core_clk, rst, reg_wr, reg_rd, sleep_instr, wake_event, standby_osc_ok, go;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic sleep_active, core_resume, brownout_detector_off, comparator_mux_block;
  logic [2:0] sleep_mode_out, m;
  logic [4:0] gates;
  logic por_low, ext_reset_n, wdt_expire, wdt_enabled, brownout_low, brownout_en;
  logic debug_reset_reg, source_reset, internal_reset, b;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int lat, base, n;

  sarc_top #(.TOUT_CYC(TOUT)) sarc_top_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .sleep_instr, .wake_event, .standby_osc_ok, .sleep_active, .sleep_mode_out, .core_resume,
    .brownout_detector_off, .gate_lcd_controller(gates[4]), .gate_timer_16bit(gates[3]),
    .gate_spi_module(gates[2]), .gate_usart_module(gates[1]), .gate_adc_module(gates[0]),
    .comparator_mux_block, .por_low, .ext_reset_n, .wdt_expire, .wdt_enabled, .brownout_low,
    .brownout_en, .debug_reset_reg, .source_reset, .internal_reset);
  sarc_core_model #(.WAKE_DLY(3)) sarc_core_model_inst (.core_clk, .rst, .go, .sleep_active,
    .sleep_instr, .wake_event);

  // Clock and a hang guard well above the few hundred cycles needed.
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  // ----
  // Bus tasks and helpers.
  // ----
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(nm, e, reg_rdata)
  endtask
  // Latency runs from seen sleep to resume; -1 means no sleep at all.
  task automatic do_sleep(output int l, output logic [2:0] md, output logic bo);
    @(posedge core_clk) go <= 1'b1;
    @(posedge core_clk) go <= 1'b0;
    l = -1;
    for (int i = 0; i < 6 && sleep_active !== 1'b1; i++) @(posedge core_clk);
    md = sleep_mode_out;
    bo = brownout_detector_off;
    if (sleep_active === 1'b1) begin
      for (l = 0; l < 60 && core_resume !== 1'b1; l++) @(posedge core_clk);
      wr(SARC_SMC_OFS, 8'h00);
    end
  endtask
  task automatic src(input int k, input logic v);
    case (k)
      0: por_low <= v;
      1: ext_reset_n <= !v;
      2: brownout_low <= v;
      3: debug_reset_reg <= v;
      default: wdt_expire <= v;
    endcase
  endtask

  // ----
  // Test sequence.
  // ----
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd, go} = '0;
    {por_low, wdt_expire, brownout_low, debug_reset_reg} = '0;
    {ext_reset_n, wdt_enabled, brownout_en, standby_osc_ok} = 4'hF;
    rst = 1'b1;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    for (n = 0; n < 60 && internal_reset !== 1'b0; n++) @(posedge core_clk);
    foreach (ADDRS[k]) rchk("reset_val", ADDRS[k], 8'h00);
    $display("Test reset_values done");
    wr(SARC_PCG_OFS, 8'hFF);
    rchk("pcg_rsvd", SARC_PCG_OFS, 8'h1F);
    `CHK("gates", 5'h1F, gates)
    `CHK("cmp_block", 1'b1, comparator_mux_block)
    wr(SARC_PCG_OFS, 8'h08);
    rchk("pcg", SARC_PCG_OFS, 8'h08);
    `CHK("gates", 5'h08, gates)
    $display("Test gating done");
    foreach (MODES[k]) begin
      wr(SARC_SMC_OFS, {4'h0, MODES[k], 1'b1});
      do_sleep(lat, m, b);
      `CHK("mode", MODES[k], m)
      `CHK("bod_off", 1'b0, b)
      if (k == 0) base = lat;
      `CHK("wake_lat", (MODES[k] == 3'h6) ? base + SARC_STANDBY_WAKE_CYC : base, lat)
    end
    // Standby without a crystal falls back to power-down and wakes at once.
    standby_osc_ok <= 1'b0;
    wr(SARC_SMC_OFS, 8'h0D);
    do_sleep(lat, m, b);
    `CHK("stby_no_xtal", {SARC_MODE_PDOWN, base}, {m, lat})
    foreach (REFUSE[k]) begin
      wr(SARC_SMC_OFS, REFUSE[k]);
      do_sleep(lat, m, b);
      `CHK("no_sleep", -1, lat)
    end
    $display("Test sleep_modes done");
    wr(SARC_CBS_OFS, 8'h40);
    rchk("brownout_off_in_sleep_alone", SARC_RSTSTAT_OFS, 8'h00);
    wr(SARC_CBS_OFS, 8'h60);
    rchk("window_open", SARC_RSTSTAT_OFS, 8'h08);
    repeat (4) @(posedge core_clk);
    wr(SARC_CBS_OFS, 8'h40);
    rchk("brownout_off_in_sleep_late", SARC_RSTSTAT_OFS, 8'h00);
    wr(SARC_SMC_OFS, 8'h05);
    wr(SARC_CBS_OFS, 8'h60);
    wr(SARC_CBS_OFS, 8'h40);
    @(posedge core_clk);
    do_sleep(lat, m, b);
    `CHK("bod_off", 1'b1, b)
    rchk("brownout_off_in_sleep_clr", SARC_RSTSTAT_OFS, 8'h00);
    $display("Test brownout_sleep done");
    for (int k = 0; k < 5; k++) begin
      wr(SARC_PCG_OFS, 8'h1F);
      src(k, 1'b1);
      @(posedge core_clk);
      if (k == 4) src(k, 1'b0);
      #1 `CHK("src_rst", 2'h3, {source_reset, internal_reset})
      @(posedge core_clk) src(k, 1'b0);
      for (n = 0; n < 40 && internal_reset !== 1'b0; n++) @(posedge core_clk);
      `CHK("stretch", 1'b1, n >= TOUT && n <= TOUT + 6)
      rchk("pcg_after_rst", SARC_PCG_OFS, 8'h00);
    end
    @(posedge core_clk) brownout_en <= 1'b0;
    wdt_enabled <= 1'b0;
    @(posedge core_clk) brownout_low <= 1'b1;
    wdt_expire <= 1'b1;
    @(posedge core_clk) wdt_expire <= 1'b0;
    #1 `CHK("src_off", 1'b0, source_reset)
    @(posedge core_clk) brownout_low <= 1'b0;
    $display("Test reset_sources done");
    complete_run();
  end
endmodule

`default_nettype wire
